// ===== include/hbfm_regs.vh
`ifndef HBFM_REGS_VH
`define HBFM_REGS_VH

// ==========================================
// timing
`define HBFM_CLK_MHZ      10
`define HBFM_SRR_HOLD_US  100
`define HBFM_OC_DELAY_US  10
`define HBFM_UL_DELAY_US  100

// ==========================================
// geometry
`define HBFM_CHANNELS     10
`define HBFM_GROUP_CH     5
`define HBFM_FRAME_BITS   16

// ==========================================
// command word fields
`define HBFM_CMD_SRR      0
`define HBFM_CMD_EN_LSB   1
`define HBFM_CMD_CFG_LSB  6
`define HBFM_CMD_ULSD     11
`define HBFM_CMD_OVERVOLTAGE_LOCKOUT_ENABLE     12
`define HBFM_CMD_GSEL     13
`define HBFM_CMD_RESET    16'h0000

// ==========================================
// status word fields
`define HBFM_ST_TSD       15
`define HBFM_ST_TW        14
`define HBFM_ST_OC        13
`define HBFM_ST_UL        12
`define HBFM_ST_PSF       11
`define HBFM_ST_CODE_LSB  1
`define HBFM_ST_GSEL      0
`define HBFM_ST_RESET     16'h0000

// ==========================================
// channel fault codes
`define HBFM_CODE_NONE    2'h0
`define HBFM_CODE_OC      2'h1
`define HBFM_CODE_UL      2'h2

`endif

// ===== verilog/hbfm_sync.v
`timescale 1ns/10ps
`default_nettype none

module hbfm_sync #(
	parameter W = 1
) (
	input  wire         clock,
	input  wire         rstn,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule

`default_nettype wire

// ===== verilog/hbfm_fault_mgr.v
`timescale 1ns/10ps
`default_nettype none
`include "hbfm_regs.vh"

// Contract
// - clear request clears latched status and re-enables faulted outputs in selected group.
// - clear acts at chip select rise and starts a holdoff; host waits it out.
// - fault still present after clear shuts the outputs down again.
// - enable pin toggle or logic power-on reset clears status.
// - shifted status frozen during frame; refreshed after frame end without clear.
// - driver supply undervoltage turns outputs off, sets supply flag, auto-recovers.
// - during driver undervoltage serial link works and commands are kept and accepted.
// - logic supply undervoltage turns outputs off and clears command and status.
// - overvoltage always sets supply flag; outputs off only with lockout enable.
// - commands accepted during overvoltage lockout, applied on recovery.
// - persistent overcurrent past filter latches channel off, global flag, code 01.
// - overcurrent code has priority over every other channel fault.
// - underload uses one shared delay timer; later channels wait its remainder.
// - expired underload latches flag and code 10; shuts off only when enabled.
// - thermal warning follows sensor automatically and never touches outputs.
// - overtemperature latches channel off, sets warning and shutdown; clear once cooled.
// - shutdown flag appears on serial output at chip select fall.
// - output settings may change during lockout; new or old state resumes.
// - underload then overcurrent reports 10 then 01; overcurrent set drops the underload latch, so code 00 after clear.
// - first output bit is shutdown flag ORed with serial input, then status.
module hbfm_fault_mgr #(
	parameter [15:0] SRR_HOLD_CYC = `HBFM_SRR_HOLD_US * `HBFM_CLK_MHZ,
	parameter [15:0] OC_DELAY_CYC = `HBFM_OC_DELAY_US * `HBFM_CLK_MHZ,
	parameter [15:0] UL_DELAY_CYC = `HBFM_UL_DELAY_US * `HBFM_CLK_MHZ
) (
	input  wire       clock,
	input  wire       rstn,
	input  wire       chip_select_low,
	input  wire       serial_clk,
	input  wire       serial_in,
	output wire       serial_out,
	output wire       serial_out_oe,
	input  wire       enable_pin,
	input  wire       logic_supply_under,
	input  wire [1:0] supply_under,
	input  wire [1:0] supply_over,
	input  wire [9:0] oc_detect,
	input  wire [9:0] ul_detect,
	input  wire [9:0] tw_detect,
	input  wire [9:0] tsd_detect,
	output wire [9:0] hs_on,
	output wire [9:0] ls_on,
	output wire       supply_fail_flag,
	output wire       underload_flag,
	output wire       overcurrent_flag,
	output wire       thermal_warning_flag,
	output wire       tsd_flag
);

	localparam NCH  = `HBFM_CHANNELS;
	localparam GCH  = `HBFM_GROUP_CH;
	localparam SYNW = 49;

	// ==========================================
	// channel fault code encoding, overcurrent first
	function [1:0] fault_code;
		input oc;
		input ul;
		begin
			if (oc)
				fault_code = `HBFM_CODE_OC;
			else if (ul)
				fault_code = `HBFM_CODE_UL;
			else
				fault_code = `HBFM_CODE_NONE;
		end
	endfunction

	// ==========================================
	// input synchronisers
	wire [SYNW-1:0] raw_in;
	wire [SYNW-1:0] syn;

	assign raw_in = {~chip_select_low, serial_clk, serial_in, enable_pin, logic_supply_under,
			 supply_under, supply_over, oc_detect, ul_detect, tw_detect, tsd_detect};

	hbfm_sync #(
		.W (SYNW)
	) u_sync (
		.clock (clock),
		.rstn  (rstn),
		.d     (raw_in),
		.q     (syn)
	);

	wire       csn_s  = ~syn[48]; // synced inverted so reset reads as deselected
	wire       sck_s  = syn[47];
	wire       si_s   = syn[46];
	wire       en_s   = syn[45];
	wire       vcc_uv = syn[44];
	wire [1:0] uv_s   = syn[43:42];
	wire [1:0] ov_s   = syn[41:40];
	wire [9:0] oc_s   = syn[39:30];
	wire [9:0] ul_s   = syn[29:20];
	wire [9:0] tw_s   = syn[19:10];
	wire [9:0] tsd_s  = syn[9:0];

	reg csn_d1_q;
	reg sck_d1_q;
	reg en_d1_q;

	wire frame_start = csn_d1_q & ~csn_s;
	wire frame_end   = ~csn_d1_q & csn_s;
	wire sck_rise    = sck_s & ~sck_d1_q;
	wire en_toggle   = en_s ^ en_d1_q;
	wire clr_all     = vcc_uv | en_toggle;

	// ==========================================
	// registers
	reg  [15:0] rx_q;
	reg  [15:0] tx_q;
	reg  [15:0] snap_q;
	reg  [4:0]  bits_q;
	reg         first_q;
	reg         freeze_q;
	reg         so_q;
	reg         so_oe_q;
	reg  [9:0]  en_q;
	reg  [9:0]  cfg_q;
	reg         gsel_q;
	reg         overvoltage_lockout_enable_q;
	reg         ulsd_q;
	reg  [15:0] hold_q;
	reg         srr_go_q;
	reg         srr_grp_q;
	reg  [15:0] oc_cnt_q [0:NCH-1];
	reg  [15:0] ul_cnt_q;
	reg  [9:0]  oc_lat_q;
	reg  [9:0]  ul_lat_q;
	reg  [9:0]  tsd_lat_q;
	reg  [9:0]  hs_q;
	reg  [9:0]  ls_q;
	reg         psf_q;
	reg         ulf_q;
	reg         ocf_q;
	reg         twf_q;
	reg         tsdf_q;
	reg  [15:0] live_d;
	reg  [9:0]  oc_set_d;
	integer     i;
	integer     j;
	integer     k;
	integer     m;

	wire        frame_ok = (bits_q >= `HBFM_FRAME_BITS);
	wire [4:0]  base     = rx_q[`HBFM_CMD_GSEL] ? 5'h5 : 5'h0;

	// ==========================================
	// edge history
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			csn_d1_q <= 1'b1;
			sck_d1_q <= 1'b0;
			en_d1_q  <= 1'b0;
		end else begin
			csn_d1_q <= csn_s;
			sck_d1_q <= sck_s;
			en_d1_q  <= en_s;
		end
	end

	// ==========================================
	// live status of the selected group
	always @* begin
		live_d                 = `HBFM_ST_RESET;
		live_d[`HBFM_ST_TSD]   = tsdf_q;
		live_d[`HBFM_ST_TW]    = twf_q;
		live_d[`HBFM_ST_OC]    = ocf_q;
		live_d[`HBFM_ST_UL]    = ulf_q;
		live_d[`HBFM_ST_PSF]   = psf_q;
		live_d[`HBFM_ST_GSEL]  = gsel_q;
		for (i = 0; i < GCH; i = i + 1) begin
			live_d[`HBFM_ST_CODE_LSB + 2*i +: 2] =
				fault_code(oc_lat_q[(gsel_q ? GCH : 0) + i], ul_lat_q[(gsel_q ? GCH : 0) + i]);
		end
	end

	// ==========================================
	// serial link and command register
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rx_q      <= `HBFM_CMD_RESET;
			tx_q      <= `HBFM_ST_RESET;
			snap_q    <= `HBFM_ST_RESET;
			bits_q    <= 5'h0;
			first_q   <= 1'b0;
			freeze_q  <= 1'b0;
			so_q      <= 1'b0;
			so_oe_q   <= 1'b0;
			en_q      <= 10'h000;
			cfg_q     <= 10'h000;
			gsel_q    <= 1'b0;
			overvoltage_lockout_enable_q    <= 1'b0;
			ulsd_q    <= 1'b0;
			hold_q    <= 16'h0000;
			srr_go_q  <= 1'b0;
			srr_grp_q <= 1'b0;
		end else if (vcc_uv) begin
			rx_q      <= `HBFM_CMD_RESET;
			tx_q      <= `HBFM_ST_RESET;
			snap_q    <= `HBFM_ST_RESET;
			bits_q    <= 5'h0;
			first_q   <= 1'b0;
			freeze_q  <= 1'b0;
			so_q      <= 1'b0;
			so_oe_q   <= 1'b0;
			en_q      <= 10'h000;
			cfg_q     <= 10'h000;
			gsel_q    <= 1'b0;
			overvoltage_lockout_enable_q    <= 1'b0;
			ulsd_q    <= 1'b0;
			hold_q    <= 16'h0000;
			srr_go_q  <= 1'b0;
			srr_grp_q <= 1'b0;
		end else begin
			srr_go_q <= 1'b0;
			if (hold_q != 16'h0000)
				hold_q <= hold_q - 16'h0001;
			if (csn_s && !freeze_q && !frame_end)
				snap_q <= live_d;
			if (frame_start) begin
				tx_q    <= snap_q;
				bits_q  <= 5'h0;
				first_q <= 1'b1;
				so_oe_q <= 1'b1;
				so_q    <= tsdf_q | si_s;
			end else if (!csn_s) begin
				if (sck_rise) begin
					rx_q    <= {rx_q[14:0], si_s};
					tx_q    <= {tx_q[14:0], 1'b0};
					so_q    <= tx_q[15];
					first_q <= 1'b0;
					if (bits_q != 5'h1F)
						bits_q <= bits_q + 5'h01;
				end else if (first_q) begin
					so_q <= tsdf_q | si_s;
				end
			end else if (frame_end) begin
				so_oe_q <= 1'b0;
				so_q    <= 1'b0;
				first_q <= 1'b0;
				if (frame_ok) begin
					// commands land even during supply lockout
					gsel_q   <= rx_q[`HBFM_CMD_GSEL];
					overvoltage_lockout_enable_q   <= rx_q[`HBFM_CMD_OVERVOLTAGE_LOCKOUT_ENABLE];
					ulsd_q   <= rx_q[`HBFM_CMD_ULSD];
					freeze_q <= rx_q[`HBFM_CMD_SRR];
					for (j = 0; j < GCH; j = j + 1) begin
						en_q[base + j]  <= rx_q[`HBFM_CMD_EN_LSB + j];
						cfg_q[base + j] <= rx_q[`HBFM_CMD_CFG_LSB + j];
					end
					if (rx_q[`HBFM_CMD_SRR] && hold_q == 16'h0000) begin
						srr_go_q  <= 1'b1;
						srr_grp_q <= rx_q[`HBFM_CMD_GSEL];
						hold_q    <= SRR_HOLD_CYC;
					end
				end
			end
		end
	end

	// ==========================================
	// protection latches and filters
	wire [9:0] grp_mask = srr_grp_q ? 10'h3E0 : 10'h01F;
	wire [9:0] clr_ch   = {NCH{clr_all}} | ({NCH{srr_go_q}} & grp_mask);
	wire [9:0] ul_pend  = ul_s & ~ul_lat_q & ~oc_lat_q;
	wire       ul_exp   = (ul_cnt_q == UL_DELAY_CYC);
	wire [9:0] ul_set   = ul_pend & {NCH{ul_exp}};

	always @* begin
		for (k = 0; k < NCH; k = k + 1)
			oc_set_d[k] = oc_s[k] && !oc_lat_q[k] && (oc_cnt_q[k] == OC_DELAY_CYC - 16'h0001);
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (m = 0; m < NCH; m = m + 1)
				oc_cnt_q[m] <= 16'h0000;
			ul_cnt_q  <= 16'h0000;
			oc_lat_q  <= 10'h000;
			ul_lat_q  <= 10'h000;
			tsd_lat_q <= 10'h000;
		end else begin
			for (m = 0; m < NCH; m = m + 1) begin
				if (oc_lat_q[m] || !oc_s[m] || clr_ch[m])
					oc_cnt_q[m] <= 16'h0000;
				else if (!oc_set_d[m])
					oc_cnt_q[m] <= oc_cnt_q[m] + 16'h0001;
			end
			if (ul_pend == 10'h000)
				ul_cnt_q <= 16'h0000;
			else if (!ul_exp)
				ul_cnt_q <= ul_cnt_q + 16'h0001;
			// a set in the clearing cycle wins
			oc_lat_q  <= oc_set_d | (oc_lat_q & ~clr_ch);
			ul_lat_q  <= (ul_set | (ul_lat_q & ~clr_ch)) & ~oc_set_d;
			tsd_lat_q <= tsd_s | (tsd_lat_q & ~(clr_ch & ~tsd_s));
		end
	end

	// ==========================================
	// drivers and global flags
	wire       uv_lock = |uv_s;
	wire       ov_any  = |ov_s;
	wire       lockout = uv_lock | (ov_any & overvoltage_lockout_enable_q) | ~en_s | vcc_uv;
	wire [9:0] kill    = oc_lat_q | tsd_lat_q | (ul_lat_q & {NCH{ulsd_q}});

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hs_q   <= 10'h000;
			ls_q   <= 10'h000;
			psf_q  <= 1'b0;
			ulf_q  <= 1'b0;
			ocf_q  <= 1'b0;
			twf_q  <= 1'b0;
			tsdf_q <= 1'b0;
		end else begin
			hs_q   <= en_q & cfg_q & ~kill & {NCH{~lockout}};
			ls_q   <= en_q & ~cfg_q & ~kill & {NCH{~lockout}};
			psf_q  <= uv_lock | ov_any;
			ulf_q  <= |ul_lat_q;
			ocf_q  <= |oc_lat_q;
			twf_q  <= |(tw_s | tsd_lat_q);
			tsdf_q <= |tsd_lat_q;
		end
	end

	assign serial_out           = so_q;
	assign serial_out_oe        = so_oe_q;
	assign hs_on                = hs_q;
	assign ls_on                = ls_q;
	assign supply_fail_flag     = psf_q;
	assign underload_flag       = ulf_q;
	assign overcurrent_flag     = ocf_q;
	assign thermal_warning_flag = twf_q;
	assign tsd_flag             = tsdf_q;

endmodule

`default_nettype wire

// ===== testbench/hbfm_fault_mgr_assertions.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// port checks of the fault manager
module hbfm_fault_mgr_assertions #(
	parameter [15:0] SRR_HOLD_CYC = 16'h03E8,
	parameter [15:0] OC_DELAY_CYC = 16'h0064,
	parameter [15:0] UL_DELAY_CYC = 16'h03E8
) (
	input wire logic       clock,
	input wire logic       rstn,
	input wire logic       chip_select_low,
	input wire logic       serial_clk,
	input wire logic       serial_in,
	input wire logic       serial_out,
	input wire logic       serial_out_oe,
	input wire logic       logic_supply_under,
	input wire logic [1:0] supply_under,
	input wire logic [1:0] supply_over,
	input wire logic [9:0] oc_detect,
	input wire logic [9:0] ul_detect,
	input wire logic [9:0] tw_detect,
	input wire logic [9:0] tsd_detect,
	input wire logic [9:0] hs_on,
	input wire logic [9:0] ls_on,
	input wire logic       supply_fail_flag,
	input wire logic       underload_flag,
	input wire logic       overcurrent_flag,
	input wire logic       thermal_warning_flag,
	input wire logic       tsd_flag
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	wire drv_off = (hs_on == 10'h000) && (ls_on == 10'h000);

	a_uv_off: assert property ((supply_under != 2'h0) [*5] |-> drv_off && supply_fail_flag)
		else $error("drivers on in undervoltage");
	a_ov_flag: assert property ((supply_over != 2'h0) [*5] |-> supply_fail_flag)
		else $error("supply flag low in overvoltage");
	a_lsu_off: assert property (logic_supply_under [*5] |-> drv_off)
		else $error("drivers on in logic undervoltage");
	a_tsd_off: assert property (tsd_detect[0] [*6] |-> !hs_on[0] && !ls_on[0] && tsd_flag && thermal_warning_flag)
		else $error("channel on above shutdown level");
	a_tw_set: assert property ((tw_detect != 10'h000) [*5] |-> thermal_warning_flag)
		else $error("warning flag missing");
	a_oc_filter: assert property ($rose(overcurrent_flag) |-> $past(oc_detect != 10'h000, 3))
		else $error("overcurrent latched unfiltered");
	a_ul_filter: assert property ($rose(underload_flag) |-> $past(ul_detect != 10'h000, 4))
		else $error("underload latched unfiltered");
	a_tsd_first: assert property ($fell(chip_select_low) && !serial_clk && !serial_in
		|-> ##[2:6] serial_out_oe && serial_out == tsd_flag) else $error("first bit wrong");

	c_oc: cover property ($rose(overcurrent_flag));
	c_ul: cover property ($rose(underload_flag));
	c_tsd: cover property ($rose(tsd_flag));
endmodule

bind hbfm_fault_mgr hbfm_fault_mgr_assertions #(.SRR_HOLD_CYC(SRR_HOLD_CYC), .OC_DELAY_CYC(OC_DELAY_CYC),
	.UL_DELAY_CYC(UL_DELAY_CYC)) u_chk (.clock(clock), .rstn(rstn), .chip_select_low(chip_select_low),
	.serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
	.logic_supply_under(logic_supply_under), .supply_under(supply_under), .supply_over(supply_over),
	.oc_detect(oc_detect), .ul_detect(ul_detect), .tw_detect(tw_detect), .tsd_detect(tsd_detect),
	.hs_on(hs_on), .ls_on(ls_on), .supply_fail_flag(supply_fail_flag), .underload_flag(underload_flag),
	.overcurrent_flag(overcurrent_flag), .thermal_warning_flag(thermal_warning_flag), .tsd_flag(tsd_flag));
`default_nettype wire

// ===== testbench/hbfm_host.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// serial host, 800 ns link clock
module hbfm_host (
	input  wire logic clock,
	output var logic  chip_select_low,
	output var logic  serial_clk,
	output var logic  serial_in,
	input  wire logic serial_out
);
	initial begin
		chip_select_low = 1'h1;
		serial_clk = 1'h0;
		serial_in = 1'h0;
	end

	task automatic xfer(input logic [15:0] cmd, output logic pre, output logic [15:0] st);
		integer i;
		chip_select_low <= 1'h0;
		repeat (6) @(posedge clock);
		pre = serial_out;
		serial_in <= cmd[15];
		repeat (4) @(posedge clock);
		for (i = 15; i >= 0; i = i - 1) begin
			serial_clk <= 1'h1;
			repeat (4) @(posedge clock);
			serial_clk <= 1'h0;
			serial_in <= (i > 0) ? cmd[i - 1] : 1'h0;
			repeat (4) @(posedge clock);
			st[i] = serial_out;
		end
		chip_select_low <= 1'h1;
		repeat (8) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// fault manager bench
module testbench;
	logic        clock, rstn, chip_select_low, serial_clk, serial_in, serial_out, serial_out_oe;
	logic        enable_pin, logic_supply_under, pre;
	logic [1:0]  supply_under, supply_over;
	logic [9:0]  oc_detect, ul_detect, tw_detect, tsd_detect, hs_on, ls_on;
	logic        supply_fail_flag, underload_flag, overcurrent_flag, thermal_warning_flag, tsd_flag;
	logic [15:0] st;
	integer      bad_count, n_compared;

	hbfm_fault_mgr #(.SRR_HOLD_CYC(16'h0004), .OC_DELAY_CYC(16'h0003), .UL_DELAY_CYC(16'h0005)) u_hbfm_fault_mgr (
		.clock(clock), .rstn(rstn), .chip_select_low(chip_select_low), .serial_clk(serial_clk),
		.serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .enable_pin(enable_pin),
		.logic_supply_under(logic_supply_under), .supply_under(supply_under), .supply_over(supply_over),
		.oc_detect(oc_detect), .ul_detect(ul_detect), .tw_detect(tw_detect), .tsd_detect(tsd_detect),
		.hs_on(hs_on), .ls_on(ls_on), .supply_fail_flag(supply_fail_flag), .underload_flag(underload_flag),
		.overcurrent_flag(overcurrent_flag), .thermal_warning_flag(thermal_warning_flag), .tsd_flag(tsd_flag));

	hbfm_host host (.clock(clock), .chip_select_low(chip_select_low), .serial_clk(serial_clk),
		.serial_in(serial_in), .serial_out(serial_out));

	task automatic ck(input logic [23:0] got, input logic [23:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic sx(input logic [15:0] cmd);
		host.xfer(cmd, pre, st);
	endtask

	task automatic cyc(input integer n);
		repeat (n) @(posedge clock);
	endtask

	task automatic wrap_up;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end

	initial begin
		#2000000;
		bad_count = bad_count + 1;
		wrap_up;
	end

	initial begin
		rstn = 1'h0;
		enable_pin = 1'h1;
		logic_supply_under = 1'h0;
		supply_under = 2'h0;
		supply_over = 2'h0;
		oc_detect = 10'h000;
		ul_detect = 10'h000;
		tw_detect = 10'h000;
		tsd_detect = 10'h000;
		bad_count = 0;
		n_compared = 0;
		cyc(3);
		rstn <= 1'h1;
		cyc(5);
		ck({hs_on, ls_on, supply_fail_flag, underload_flag, overcurrent_flag, tsd_flag}, 24'h0);
		sx(16'h057E);
		oc_detect <= 10'h002;
		cyc(10);
		oc_detect <= 10'h000;
		ul_detect <= 10'h002;
		cyc(10);
		ul_detect <= 10'h000;
		ck({overcurrent_flag, underload_flag, hs_on, ls_on}, {2'h2, 10'h015, 10'h008});
		sx(16'h057E);
		sx(16'h057E);
		ck({pre, st}, 17'h02008);
		$display("test overcurrent done");
		sx(16'h057F);
		ck({overcurrent_flag, ls_on}, 11'h00A);
		oc_detect <= 10'h002;
		cyc(10);
		sx(16'h057F);
		cyc(6);
		ck({overcurrent_flag, ls_on}, 11'h408);
		oc_detect <= 10'h000;
		sx(16'h057F);
		ck({overcurrent_flag, ls_on}, 11'h00A);
		$display("test clear done");
		supply_under <= 2'h1;
		cyc(6);
		ck({supply_fail_flag, hs_on, ls_on}, {1'h1, 20'h0});
		sx(16'h0046);
		ck({hs_on, ls_on}, 20'h0);
		supply_under <= 2'h0;
		cyc(6);
		ck({supply_fail_flag, hs_on, ls_on}, {1'h0, 10'h001, 10'h002});
		supply_over <= 2'h2;
		cyc(6);
		ck({supply_fail_flag, hs_on, ls_on}, {1'h1, 10'h001, 10'h002});
		sx(16'h1046);
		ck({hs_on, ls_on}, 20'h0);
		sx(16'h157E);
		ck({hs_on, ls_on}, 20'h0);
		supply_over <= 2'h0;
		cyc(6);
		ck({supply_fail_flag, hs_on, ls_on}, {1'h0, 10'h015, 10'h00A});
		$display("test supply done");
		ul_detect <= 10'h008;
		cyc(3);
		ul_detect <= 10'h018;
		cyc(8);
		ul_detect <= 10'h000;
		ck({underload_flag, hs_on, ls_on}, {1'h1, 10'h015, 10'h00A});
		sx(16'h157E);
		sx(16'h157E);
		ck(st, 16'h1500);
		sx(16'h1D7F);
		ck(underload_flag, 1'h0);
		ul_detect <= 10'h004;
		cyc(10);
		ul_detect <= 10'h000;
		ck({underload_flag, hs_on}, {1'h1, 10'h011});
		sx(16'h1D7F);
		ck(hs_on, 10'h015);
		$display("test underload done");
		tw_detect <= 10'h080;
		cyc(5);
		ck({thermal_warning_flag, hs_on, ls_on}, {1'h1, 10'h015, 10'h00A});
		tw_detect <= 10'h000;
		cyc(5);
		ck(thermal_warning_flag, 1'h0);
		tsd_detect <= 10'h001;
		cyc(6);
		ck({tsd_flag, thermal_warning_flag, hs_on}, {2'h3, 10'h014});
		sx(16'h1D7E);
		ck(pre, 1'h1);
		sx(16'h1D7F);
		ck(tsd_flag, 1'h1);
		tsd_detect <= 10'h000;
		cyc(6);
		sx(16'h1D7F);
		ck({tsd_flag, hs_on}, {1'h0, 10'h015});
		$display("test thermal done");
		oc_detect <= 10'h002;
		cyc(10);
		oc_detect <= 10'h000;
		enable_pin <= 1'h0;
		cyc(6);
		enable_pin <= 1'h1;
		cyc(6);
		ck(overcurrent_flag, 1'h0);
		logic_supply_under <= 1'h1;
		cyc(6);
		logic_supply_under <= 1'h0;
		cyc(6);
		ck({hs_on, ls_on}, 20'h0);
		sx(16'h0000);
		ck(st, 16'h0000);
		$display("test reset paths done");
		wrap_up;
	end
endmodule
`default_nettype wire
